/* src/cri_pkg.sv */
package cri_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] ADDR_RX_IE = 8'h00;
  localparam logic [7:0] ADDR_TX_IE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_TX_FLAG = 8'h0c;
  localparam logic [7:0] ADDR_CTRL = 8'h10;

  // ==========================================================
  // field positions
  localparam int BIT_WAKE = 7;
  localparam int BIT_CSC = 6;
  localparam int RSENS_LSB = 4;
  localparam int TSENS_LSB = 2;
  localparam int BIT_OVR = 1;
  localparam int BIT_RXF = 0;
  localparam int BIT_WAKEUP_FUNCTION_EN = 0;
  localparam int NUM_TXBUF = 3;

  // ==========================================================
  // reset values
  localparam logic [7:0] RX_IE_RST = 8'h00;
  localparam logic [2:0] TX_IE_RST = 3'h0;
  localparam logic CTRL_RST = 1'b0;

  // ==========================================================
  // error states and sensitivity codes
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_WRN = 2'h1;
  localparam logic [1:0] ST_ERR = 2'h2;
  localparam logic [1:0] ST_BOFF = 2'h3;
  localparam logic [1:0] SENS_NONE = 2'h0;
  localparam logic [1:0] SENS_BOFF = 2'h1;
  localparam logic [1:0] SENS_WRN = 2'h2;
  localparam logic [1:0] SENS_ALL = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // types
  typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} cri_wr_e;
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} cri_rd_e;

  typedef struct packed {
    logic wakeup;
    logic error;
    logic rx;
    logic tx;
    logic any;
    logic recover;
  } cri_irq_s;

  typedef struct packed {
    logic [1:0] flags;
  } cri_trk_s;

  // ==========================================================
  // functions
  function automatic logic sens_hit(input logic [1:0] sens,
                                    input logic [1:0] old_st,
                                    input logic [1:0] new_st);
    logic edge_b;
    logic edge_w;
    edge_b = (old_st == ST_BOFF) || (new_st == ST_BOFF);
    edge_w = edge_b || (old_st == ST_WRN) || (new_st == ST_WRN);
    sens_hit = 1'b0;
    if (old_st != new_st)
    begin
      unique case (sens)
        SENS_NONE: sens_hit = 1'b0;
        SENS_BOFF: sens_hit = edge_b;
        SENS_WRN: sens_hit = edge_w;
        SENS_ALL: sens_hit = 1'b1;
      endcase
    end
  endfunction : sens_hit

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == ADDR_RX_IE) || (a == ADDR_TX_IE) ||
              (a == ADDR_STATUS) || (a == ADDR_TX_FLAG) ||
              (a == ADDR_CTRL);
  endfunction : addr_ok

endpackage : cri_pkg

/* src/cri_state_track.sv */
`timescale 1ns/1ns
`default_nettype none

module cri_state_track (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [1:0] sens_i,
  input wire logic [1:0] actual_i,
  input wire logic hold_i,
  output logic [1:0] flags_o,
  output logic change_o
);

  // ==========================================================
  // reported state flags
  cri_pkg::cri_trk_s st;
  cri_pkg::cri_trk_s nx;

  always_comb
  begin
    nx = st;
    change_o = 1'b0;
    if (!hold_i)
    begin
      // flags follow the real state unless a change is pending
      nx.flags = actual_i;
      change_o = cri_pkg::sens_hit(sens_i, st.flags, actual_i);
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= nx;
    end
  end

  assign flags_o = st.flags;

endmodule : cri_state_track

`default_nettype wire

/* src/cri_top.sv */
// How it works
// - wake-up event raises wake-up request only while bit 7 enable is set.
// - status change raises error request only while bit 6 enable is set.
// - receiver sensitivity 00 never flags; 11 flags every receiver change.
// - receiver sensitivity 01 flags only entering or leaving bus-off.
// - receiver sensitivity 10 flags warning or bus-off entry and exit.
// - receiver flags track real state but freeze while change is pending.
// - transmitter sensitivity 00 never flags; 11 flags every change.
// - transmitter 01 flags bus-off edges; 10 warning or bus-off edges.
// - transmitter flags track real state but freeze while change pending.
// - overrun raises error request only while bit 1 enable is set.
// - receive-full raises receiver request only while bit 0 enable set.
// - transmitter leaving bus-off forces receiver state to OK for one cycle.
// - each transmit-empty flag has its own enable bit.
`timescale 1ns/1ns
`default_nettype none

module cri_top (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic wakeup_evt_i,
  input wire logic overrun_evt_i,
  input wire logic rx_full_evt_i,
  input wire logic [2:0] tx_empty_evt_i,
  input wire logic [1:0] rx_state_i,
  input wire logic [1:0] tx_state_i,
  output var cri_pkg::cri_irq_s irq_o
);

  // ==========================================================
  // state
  typedef struct packed {
    cri_pkg::cri_wr_e wr_st;
    cri_pkg::cri_rd_e rd_st;
    logic aw_ok;
    logic w_ok;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] rx_ie;
    logic [2:0] tx_ie;
    logic wakeup_function_en;
    logic wake;
    logic csc;
    logic ovr;
    logic rxf;
    logic [2:0] txe;
    logic [1:0] tx_prev;
    cri_pkg::cri_irq_s irq;
  } cri_state_s;

  cri_state_s st;
  cri_state_s nx;
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [1:0] rx_eff;
  logic [1:0] rx_flags;
  logic [1:0] tx_flags;
  logic rx_hit;
  logic tx_hit;

  // ==========================================================
  // reset release
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_sync_reg <= 2'h0;
    end
    else
    begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ==========================================================
  // receiver state seen by the flags
  always_comb
  begin
    if (tx_state_i == cri_pkg::ST_BOFF)
    begin
      rx_eff = cri_pkg::ST_BOFF;
    end
    else if (st.tx_prev == cri_pkg::ST_BOFF)
    begin
      rx_eff = cri_pkg::ST_OK;
    end
    else
    begin
      rx_eff = rx_state_i;
    end
  end

  // ==========================================================
  // state change trackers
  cri_state_track u_rx_trk (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(rst_n),
    .sens_i(st.rx_ie[cri_pkg::RSENS_LSB +: 2]),
    .actual_i(rx_eff),
    .hold_i(st.csc),
    .flags_o(rx_flags),
    .change_o(rx_hit)
  );

  cri_state_track u_tx_trk (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(rst_n),
    .sens_i(st.rx_ie[cri_pkg::TSENS_LSB +: 2]),
    .actual_i(tx_state_i),
    .hold_i(st.csc),
    .flags_o(tx_flags),
    .change_o(tx_hit)
  );

  // ==========================================================
  // next state
  always_comb
  begin
    logic [7:0] clr;
    logic [2:0] tclr;
    logic wr;
    logic [7:0] a;
    clr = 8'h00;
    tclr = 3'h0;
    wr = 1'b0;
    a = st.awaddr;
    nx = st;
    nx.tx_prev = tx_state_i;

    // write channel
    unique case (st.wr_st)
      cri_pkg::WR_IDLE:
      begin
        if (s_axi_awvalid_i && st.awready)
        begin
          nx.aw_ok = 1'b1;
          nx.awaddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && st.wready)
        begin
          nx.w_ok = 1'b1;
          nx.wdata = s_axi_wdata_i[7:0];
          nx.wstrb0 = s_axi_wstrb_i[0];
        end
        if (nx.aw_ok && nx.w_ok)
        begin
          a = nx.awaddr;
          wr = nx.wstrb0;
          nx.aw_ok = 1'b0;
          nx.w_ok = 1'b0;
          nx.bvalid = 1'b1;
          nx.bresp = cri_pkg::addr_ok(a) ? cri_pkg::RESP_OKAY
                                         : cri_pkg::RESP_SLVERR;
          nx.wr_st = cri_pkg::WR_RESP;
        end
      end
      cri_pkg::WR_RESP:
      begin
        if (s_axi_bready_i)
        begin
          nx.bvalid = 1'b0;
          nx.wr_st = cri_pkg::WR_IDLE;
        end
      end
    endcase
    nx.awready = (nx.wr_st == cri_pkg::WR_IDLE) && !nx.aw_ok;
    nx.wready = (nx.wr_st == cri_pkg::WR_IDLE) && !nx.w_ok;

    // register writes
    if (wr)
    begin
      unique case (a)
        cri_pkg::ADDR_RX_IE: nx.rx_ie = nx.wdata;
        cri_pkg::ADDR_TX_IE: nx.tx_ie = nx.wdata[2:0];
        cri_pkg::ADDR_STATUS: clr = nx.wdata;
        cri_pkg::ADDR_TX_FLAG: tclr = nx.wdata[2:0];
        cri_pkg::ADDR_CTRL: nx.wakeup_function_en = nx.wdata[cri_pkg::BIT_WAKEUP_FUNCTION_EN];
        default: clr = 8'h00;
      endcase
    end

    // sticky flags, a new event wins over a clear
    nx.wake = (st.wake & ~clr[cri_pkg::BIT_WAKE]) | wakeup_evt_i;
    nx.csc = (st.csc & ~clr[cri_pkg::BIT_CSC]) |
             rx_hit | tx_hit;
    nx.ovr = (st.ovr & ~clr[cri_pkg::BIT_OVR]) | overrun_evt_i;
    nx.rxf = (st.rxf & ~clr[cri_pkg::BIT_RXF]) | rx_full_evt_i;
    nx.txe = (st.txe & ~tclr) | tx_empty_evt_i;

    // read channel
    unique case (st.rd_st)
      cri_pkg::RD_IDLE:
      begin
        if (s_axi_arvalid_i && st.arready)
        begin
          nx.rvalid = 1'b1;
          nx.rd_st = cri_pkg::RD_DATA;
          nx.rresp = cri_pkg::addr_ok(s_axi_araddr_i)
                     ? cri_pkg::RESP_OKAY : cri_pkg::RESP_SLVERR;
          unique case (s_axi_araddr_i)
            cri_pkg::ADDR_RX_IE: nx.rdata = {24'h000000, st.rx_ie};
            cri_pkg::ADDR_TX_IE: nx.rdata = {29'h0, st.tx_ie};
            cri_pkg::ADDR_STATUS:
              nx.rdata = {24'h000000, st.wake, st.csc, rx_flags,
                          tx_flags, st.ovr, st.rxf};
            cri_pkg::ADDR_TX_FLAG: nx.rdata = {29'h0, st.txe};
            cri_pkg::ADDR_CTRL: nx.rdata = {31'h0, st.wakeup_function_en};
            default: nx.rdata = 32'h00000000;
          endcase
        end
      end
      cri_pkg::RD_DATA:
      begin
        if (s_axi_rready_i)
        begin
          nx.rvalid = 1'b0;
          nx.rd_st = cri_pkg::RD_IDLE;
        end
      end
    endcase
    nx.arready = (nx.rd_st == cri_pkg::RD_IDLE);

    // interrupt requests
    nx.irq.wakeup = st.wake & st.rx_ie[cri_pkg::BIT_WAKE];
    nx.irq.error = (st.csc & st.rx_ie[cri_pkg::BIT_CSC]) |
                   (st.ovr & st.rx_ie[cri_pkg::BIT_OVR]);
    nx.irq.rx = st.rxf & st.rx_ie[cri_pkg::BIT_RXF];
    nx.irq.tx = |(st.txe & st.tx_ie);
    nx.irq.any = nx.irq.wakeup | nx.irq.error | nx.irq.rx |
                 nx.irq.tx;
    nx.irq.recover = nx.irq.wakeup & st.wakeup_function_en;
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.wr_st <= cri_pkg::WR_IDLE;
      st.rd_st <= cri_pkg::RD_IDLE;
      st.rx_ie <= cri_pkg::RX_IE_RST;
      st.tx_ie <= cri_pkg::TX_IE_RST;
      st.wakeup_function_en <= cri_pkg::CTRL_RST;
    end
    else
    begin
      st <= nx;
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready_o = st.awready;
  assign s_axi_wready_o = st.wready;
  assign s_axi_bvalid_o = st.bvalid;
  assign s_axi_bresp_o = st.bresp;
  assign s_axi_arready_o = st.arready;
  assign s_axi_rvalid_o = st.rvalid;
  assign s_axi_rresp_o = st.rresp;
  assign s_axi_rdata_o = st.rdata;
  assign irq_o = st.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n);

  logic rx_only;
  logic tx_only;
  assign rx_only = st.rx_ie[3:2] == cri_pkg::SENS_NONE;
  assign tx_only = st.rx_ie[5:4] == cri_pkg::SENS_NONE;

  sequence s_enabled_wake;
    st.wake && st.rx_ie[cri_pkg::BIT_WAKE];
  endsequence
  a_wake_irq_gate: assert property (
    s_enabled_wake |=> irq_o.wakeup)
    else $error("wake-up request missing");
  a_wake_irq_off: assert property (
    !st.rx_ie[cri_pkg::BIT_WAKE] |=> !irq_o.wakeup)
    else $error("wake-up request while disabled");
  a_csc_irq_gate: assert property (
    st.csc && st.rx_ie[cri_pkg::BIT_CSC] |=> irq_o.error)
    else $error("status change request missing");
  a_no_sens_quiet: assert property (
    rx_only && tx_only && !st.csc |=> !st.csc)
    else $error("status change flag set with no sensitivity");
  a_rx_boff_only: assert property (
    st.rx_ie[5:4] == cri_pkg::SENS_BOFF && rx_only && !st.csc &&
    rx_flags == cri_pkg::ST_OK && rx_eff == cri_pkg::ST_WRN
    |=> !st.csc)
    else $error("warning change flagged in bus-off mode");
  a_rx_warn_sens: assert property (
    st.rx_ie[5:4] == cri_pkg::SENS_WRN && rx_only && !st.csc &&
    rx_flags == cri_pkg::ST_OK && rx_eff == cri_pkg::ST_WRN
    |=> st.csc ##1 irq_o.error || !st.rx_ie[cri_pkg::BIT_CSC])
    else $error("warning change not flagged");
  a_rx_flags_hold: assert property (
    st.csc |=> $stable(rx_flags))
    else $error("receiver flags moved while change pending");
  a_tx_flags_hold: assert property (
    st.csc |=> $stable(tx_flags))
    else $error("transmitter flags moved while change pending");
  a_tx_boff_sens: assert property (
    st.rx_ie[3:2] == cri_pkg::SENS_BOFF && tx_only && !st.csc &&
    tx_flags == cri_pkg::ST_ERR && tx_state_i == cri_pkg::ST_BOFF
    |=> st.csc)
    else $error("transmitter bus-off entry not flagged");
  a_ovr_irq_gate: assert property (
    st.ovr && st.rx_ie[cri_pkg::BIT_OVR] |=> irq_o.error)
    else $error("overrun request missing");
  a_rxf_irq_gate: assert property (
    st.rxf && st.rx_ie[cri_pkg::BIT_RXF] |=> irq_o.rx)
    else $error("receive-full request missing");
  a_rx_forced_ok: assert property (
    st.tx_prev == cri_pkg::ST_BOFF && tx_state_i == cri_pkg::ST_OK &&
    !st.csc |=> rx_flags == cri_pkg::ST_OK)
    else $error("receiver not forced to OK");
  a_tx_irq_gate: assert property (
    (st.txe & st.tx_ie) != 3'h0 |=> irq_o.tx)
    else $error("transmit-empty request missing");
  a_irq_drop: assert property (
    !(st.wake && st.rx_ie[7]) && !(st.csc && st.rx_ie[6]) &&
    !(st.ovr && st.rx_ie[1]) && !(st.rxf && st.rx_ie[0]) &&
    (st.txe & st.tx_ie) == 3'h0 |=> !irq_o.any)
    else $error("request stands without enabled flag");
  a_set_wins_clear: assert property (
    wakeup_evt_i |=> st.wake)
    else $error("wake-up event lost");

endmodule : cri_top

`default_nettype wire

/* testbench/cri_can_model.sv */
`timescale 1ns/1ns
`default_nettype none

module cri_can_model (
  input wire logic clk_sys_i,
  output logic wakeup_evt_o,
  output logic overrun_evt_o,
  output logic rx_full_evt_o,
  output logic [2:0] tx_empty_evt_o,
  output logic [1:0] rx_state_o,
  output logic [1:0] tx_state_o
);
  // ==========================================================
  // controller-side events and error states
  initial
  begin
    {wakeup_evt_o, overrun_evt_o, rx_full_evt_o, tx_empty_evt_o} = 6'h00;
    rx_state_o = 2'h0;
    tx_state_o = 2'h0;
  end

  // one-cycle event pulse, driven after a rising edge
  task automatic pulse(input logic [5:0] v);
    @(posedge clk_sys_i);
    {wakeup_evt_o, overrun_evt_o, rx_full_evt_o, tx_empty_evt_o} <= v;
    @(posedge clk_sys_i);
    {wakeup_evt_o, overrun_evt_o, rx_full_evt_o, tx_empty_evt_o} <= 6'h00;
  endtask : pulse

  task automatic set_state(input logic [1:0] rx, input logic [1:0] tx);
    @(posedge clk_sys_i);
    rx_state_o <= rx;
    tx_state_o <= tx;
  endtask : set_state
endmodule : cri_can_model

`default_nettype wire

/* testbench/can_receiver_interrupt_enables_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module can_receiver_interrupt_enables_tb_top;
  // ==========================================================
  // signals
  logic clk_sys_i, reset_n_i;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rdat;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rrsp;
  logic wake_e, ovr_e, rxf_e;
  logic [2:0] txe_e;
  logic [1:0] rx_st, tx_st;
  cri_pkg::cri_irq_s irq;
  int n_errors = 0;
  int n_compared = 0;

  cri_top cri_top_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .wakeup_evt_i(wake_e),
    .overrun_evt_i(ovr_e), .rx_full_evt_i(rxf_e),
    .tx_empty_evt_i(txe_e), .rx_state_i(rx_st), .tx_state_i(tx_st),
    .irq_o(irq));

  cri_can_model cri_can_model_inst (.clk_sys_i(clk_sys_i),
    .wakeup_evt_o(wake_e), .overrun_evt_o(ovr_e), .rx_full_evt_o(rxf_e),
    .tx_empty_evt_o(txe_e), .rx_state_o(rx_st), .tx_state_o(tx_st));

  // ==========================================================
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    @(posedge clk_sys_i);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rdat = rdata;
    rrsp = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : settle

  // ==========================================================
  // scenarios
  task automatic t_regs();
    logic [7:0] ad [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14};
    for (int i = 0; i < 5; i++)
    begin
      rd(ad[i]);
      `CHK(rdat, 32'h00000000)
      `CHK(rrsp, (i == 4) ? cri_pkg::RESP_SLVERR : cri_pkg::RESP_OKAY)
    end
    wr(8'h14, 8'hff, cri_pkg::RESP_SLVERR);
    wr(cri_pkg::ADDR_RX_IE, 8'h3c, cri_pkg::RESP_OKAY);
    rd(cri_pkg::ADDR_RX_IE);
    `CHK(rdat, 32'h0000003c)
    wstrb <= 4'he;
    wr(cri_pkg::ADDR_RX_IE, 8'hff, cri_pkg::RESP_OKAY);
    wstrb <= 4'hf;
    rd(cri_pkg::ADDR_RX_IE);
    `CHK(rdat, 32'h0000003c)
    wr(cri_pkg::ADDR_RX_IE, 8'h00, cri_pkg::RESP_OKAY);
  endtask : t_regs

  task automatic t_events();
    logic [7:0] en [3] = '{8'h80, 8'h02, 8'h01};
    logic [5:0] ev [3] = '{6'h20, 6'h10, 6'h08};
    for (int i = 0; i < 3; i++)
    begin
      cri_can_model_inst.pulse(ev[i]);
      settle(3);
      `CHK({irq.wakeup, irq.error, irq.rx}, 3'h0)
      rd(cri_pkg::ADDR_STATUS);
      `CHK(rdat[7:0] & en[i], en[i])
      wr(cri_pkg::ADDR_RX_IE, en[i], cri_pkg::RESP_OKAY);
      wr(cri_pkg::ADDR_CTRL, 8'h01, cri_pkg::RESP_OKAY);
      settle(2);
      `CHK({irq.wakeup, irq.error, irq.rx}, 3'(3'h4 >> i))
      `CHK(irq.any, 1'b1)
      `CHK(irq.recover, i == 0)
      wr(cri_pkg::ADDR_STATUS, en[i], cri_pkg::RESP_OKAY);
      settle(2);
      `CHK({irq.wakeup, irq.error, irq.rx}, 3'h0)
      `CHK(irq.any, 1'b0)
      wr(cri_pkg::ADDR_RX_IE, 8'h00, cri_pkg::RESP_OKAY);
    end
  endtask : t_events

  task automatic t_sens(input bit txs);
    logic [1:0] pr [5][2] = '{'{0, 1}, '{1, 2}, '{2, 0}, '{2, 3}, '{3, 0}};
    logic [1:0] o, n, s;
    logic hit;
    for (int si = 0; si < 4; si++)
      for (int p = 0; p < 5; p++)
      begin
        s = 2'(si);
        o = pr[p][0];
        n = pr[p][1];
        hit = (o != n) && ((s == 2'h3) || (s == 2'h1 && (&o || &n)) ||
              (s == 2'h2 && (o[0] || n[0])));
        wr(cri_pkg::ADDR_RX_IE, {2'b01, txs ? 2'h0 : s, txs ? s : 2'h0,
           2'h0}, cri_pkg::RESP_OKAY);
        cri_can_model_inst.set_state(txs ? 2'h0 : o, txs ? o : 2'h0);
        settle(3);
        wr(cri_pkg::ADDR_STATUS, 8'h40, cri_pkg::RESP_OKAY);
        settle(3);
        wr(cri_pkg::ADDR_STATUS, 8'h40, cri_pkg::RESP_OKAY);
        cri_can_model_inst.set_state(txs ? 2'h0 : n, txs ? n : 2'h0);
        settle(3);
        `CHK(irq.error, hit)
        rd(cri_pkg::ADDR_STATUS);
        `CHK(rdat[6], hit)
        `CHK(txs ? rdat[3:2] : rdat[5:4], n)
        cri_can_model_inst.set_state(txs ? 2'h0 : o, txs ? o : 2'h0);
        settle(3);
        rd(cri_pkg::ADDR_STATUS);
        if (hit)
          `CHK(txs ? rdat[3:2] : rdat[5:4], n)
        else
          `CHK(txs ? rdat[3:2] : rdat[5:4], o)
      end
  endtask : t_sens

  task automatic t_txempty();
    for (int i = 0; i < 3; i++)
    begin
      wr(cri_pkg::ADDR_TX_IE, 8'(8'h01 << i), cri_pkg::RESP_OKAY);
      cri_can_model_inst.pulse({3'h0, 3'(3'h1 << ((i + 1) % 3))});
      settle(3);
      `CHK(irq.tx, 1'b0)
      cri_can_model_inst.pulse({3'h0, 3'(3'h1 << i)});
      settle(3);
      `CHK(irq.tx, 1'b1)
      wr(cri_pkg::ADDR_TX_FLAG, 8'h07, cri_pkg::RESP_OKAY);
      settle(2);
      `CHK(irq.tx, 1'b0)
    end
  endtask : t_txempty

  // ==========================================================
  // clock, reset, sequence and verdict
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  initial
  begin
    #200000;
    n_errors++;
    conclude();
  end

  initial
  begin
    {reset_n_i, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hf;
    repeat (12) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    settle(4);
    t_regs();
    t_events();
    t_sens(1'b0);
    t_sens(1'b1);
    t_txempty();
    conclude();
  end
endmodule : can_receiver_interrupt_enables_tb_top

`undef CHK
`default_nettype wire
